// ==== include/tpol_pkg.sv ====
// constants for the timing output polarity block
// assumes: a 32-bit apb slave, one register word per index
package tpol_pkg;
  // register index, byte address is four times it
  localparam logic [7:0]  POL_REG_INDEX = 8'h56;
  localparam logic [11:0] POL_REG_ADDR  = {2'h0, POL_REG_INDEX, 2'h0};
  localparam logic [11:0] ID_REG_ADDR   = 12'h000;
  // field positions inside the polarity register
  localparam int BIT_VBLANK = 3;
  localparam int BIT_FSYNC  = 4;
  localparam int BIT_FDIG   = 5;
  localparam int BIT_DEWIN  = 7;
  localparam int BIT_TENFID = 8;
  localparam int BIT_AFM    = 9;
  // writable bits, reserved bits 15-10 and 6 read zero
  localparam logic [15:0] POL_WMASK = 16'h03b8;
  localparam logic [15:0] POL_RESET = 16'h0000;
  localparam int NUM_OUT = 6;
  // output slot order in the vector
  localparam int O_AFM = 0;
  localparam int O_TFD = 1;
  localparam int O_DEW = 2;
  localparam int O_FDG = 3;
  localparam int O_FSY = 4;
  localparam int O_VBL = 5;
  typedef enum logic [1:0] {
    APB_IDLE   = 2'b00,
    APB_SETUP  = 2'b01,
    APB_ACCESS = 2'b11
  } apb_phase_t;
endpackage

// ==== hdl/pol_xor_cell.sv ====
// one registered polarity cell
// assumes: raw timing level synchronous to the video clock
`timescale 1ns/1ps
`default_nettype none
module pol_xor_cell (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // raw timing and invert control
  input  wire logic raw,
  input  wire logic invert,
  // registered output
  output var  logic q
);
  // xor then register so the output cannot glitch
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= 1'b0;
    end else begin
      q <= raw ^ invert;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/timing_output_polarity_ctl.sv ====
// timing output polarity control with apb register access
// assumes: raw timing inputs synchronous to CLK_SYS, apb on same clock
//
// Summary of operation
// - marker invert bit flips audio frame marker
// - default marker high for whole line one
// - no-audio variant: no marker, bit ignored
// - identifier invert bit flips ten-field identifier
// - default identifier high one line per sequence
// - window invert bit flips display enable
// - default display enable high while showing pixels
// - field-flag invert bit flips digital field flag
// - default digital field flag low in field one
// - field-sync invert bit flips field sync
// - default field sync high in field one
// - default vertical blanking low during video
// - blanking invert bit flips vertical blanking
`timescale 1ns/1ps
`default_nettype none
module timing_output_polarity_ctl
  import tpol_pkg::*;
#(
  parameter bit HAS_AUDIO = 1'b1,
  parameter int ADDR_W    = 12
) (
  // clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              NRST,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output var  logic [31:0]       PRDATA,
  output var  logic              PREADY,
  output var  logic              PSLVERR,
  // raw timing from the generators, default polarity
  input  wire logic              AUDIO_FRAME_MARKER_RAW,
  input  wire logic              TEN_FIELD_IDENTIFIER_RAW,
  input  wire logic              DISPLAY_WINDOW_ENABLE_RAW,
  input  wire logic              FIELD_DIGITAL_RAW,
  input  wire logic              FIELD_SYNC_RAW,
  input  wire logic              VBLANK_RAW,
  // polarity adjusted timing outputs
  output var  logic              AUDIO_FRAME_MARKER,
  output var  logic              TEN_FIELD_IDENTIFIER,
  output var  logic              DISPLAY_WINDOW_ENABLE,
  output var  logic              FIELD_DIGITAL,
  output var  logic              FIELD_SYNC,
  output var  logic              VBLANK
);

  // ****************************************
  // parameter checks
  // ****************************************
  if (ADDR_W < 12) begin : g_bad_addr
    $error("ADDR_W must be at least 12");
  end
  // the cell vector is laid out for exactly six timing outputs
  if (NUM_OUT != 6) begin : g_bad_outs
    $error("NUM_OUT must be six");
  end

  // ****************************************
  // behaviour notes
  // ****************************************
  // register view from software:
  //   one 16-bit word in the low half of a 32-bit apb word
  //   bit 9  flips the audio frame marker
  //   bit 8  flips the ten-field identifier
  //   bit 7  flips the display window enable
  //   bit 6  reserved, never stored, reads zero
  //   bit 5  flips the digital field flag
  //   bit 4  flips the field sync
  //   bit 3  flips the vertical blanking
  //   bits 2-0 belong to the horizontal polarity block
  //   bits 15-10 reserved, never stored, read zero
  //   bits 31-16 of the apb word ignored on write, zero on read
  //
  // byte lanes:
  //   strobe lane 0 covers bits 7-0
  //   strobe lane 1 covers bits 15-8
  //   lanes 2 and 3 carry nothing and are ignored
  //
  // bus timing:
  //   setup cycle sampled at an edge raises ready for one cycle
  //   the write lands at the edge where ready is seen high
  //   read data and the error flag stand only in that cycle
  //   back to back transfers are served without gaps
  //   the dummy word at address zero reads zero, writes vanish
  //   any other PADDR[11:0] value answers with the error flag set; upper address bits are ignored
  //
  // output timing:
  //   each output is one flop behind its raw input
  //   a new invert bit reaches the pin one edge after the write
  //   so the pin can flip mid line if software writes mid line;
  //   software should write during blanking to avoid a runt
  //
  // reset:
  //   synchronous and active low; clears the register and all
  //   six output flops, so every pin sits low until the first
  //   edge after release, then follows its raw level
  //
  // variant without audio clocks:
  //   marker bit is not writable and reads zero
  //   marker pin is forced low whatever the raw input does
  //
  // hazards:
  //   raw inputs must already be in this clock domain; there is
  //   no synchroniser here, by design, to keep one flop latency
  //   the xor is registered, so a bit flip never glitches a pin

  // ****************************************
  // apb decode
  // ****************************************
  logic [15:0] polarity;     // stored register
  logic [15:0] next_pol;     // value after write
  wire  [11:0] addr12   = PADDR[11:0];
  wire         hit_pol  = (addr12 == POL_REG_ADDR);
  wire         hit_id   = (addr12 == ID_REG_ADDR);
  wire         mapped   = hit_pol | hit_id;
  wire         setup    = PSEL & ~PENABLE;
  // byte lanes of the low half word
  wire  [15:0] lane_m   = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
  // marker bit unwritable without audio
  wire  [15:0] wmask    = HAS_AUDIO ? POL_WMASK
                          : (POL_WMASK & ~(16'h0001 << BIT_AFM));
  // reserved bits never stored, so they read zero
  wire  [15:0] wr_m     = wmask & lane_m;
  wire         do_write = PSEL & PENABLE & PREADY & PWRITE & hit_pol;
  wire  [31:0] rd_val   = hit_pol ? {16'h0000, polarity} : 32'h00000000;

  always_comb begin
    next_pol = (polarity & ~wr_m) | (PWDATA[15:0] & wr_m);
  end

  // register store, clear on reset gives default polarity
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      polarity <= POL_RESET;
    end else if (do_write) begin
      polarity <= next_pol;
    end
  end

  // no wait state: answer in the first access cycle after setup
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PRDATA  <= (setup & ~PWRITE) ? rd_val : 32'h00000000;
      PSLVERR <= setup & ~mapped;
    end
  end

  // ****************************************
  // polarity cells
  // ****************************************
  wire [NUM_OUT-1:0] raw_v;   // raw timing vector
  wire [NUM_OUT-1:0] inv_v;   // invert vector
  wire [NUM_OUT-1:0] out_v;   // registered outputs

  // no-audio variant never pulses the marker
  assign raw_v[O_AFM] = HAS_AUDIO ? AUDIO_FRAME_MARKER_RAW : 1'b0;
  assign inv_v[O_AFM] = HAS_AUDIO ? polarity[BIT_AFM] : 1'b0;
  assign raw_v[O_TFD] = TEN_FIELD_IDENTIFIER_RAW;
  assign inv_v[O_TFD] = polarity[BIT_TENFID];
  assign raw_v[O_DEW] = DISPLAY_WINDOW_ENABLE_RAW;
  assign inv_v[O_DEW] = polarity[BIT_DEWIN];
  assign raw_v[O_FDG] = FIELD_DIGITAL_RAW;
  assign inv_v[O_FDG] = polarity[BIT_FDIG];
  assign raw_v[O_FSY] = FIELD_SYNC_RAW;
  assign inv_v[O_FSY] = polarity[BIT_FSYNC];
  assign raw_v[O_VBL] = VBLANK_RAW;
  assign inv_v[O_VBL] = polarity[BIT_VBLANK];

  // one registered xor per output
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_cell
    pol_xor_cell u_cell (
      .clk    (CLK_SYS),
      .nrst   (NRST),
      .raw    (raw_v[i]),
      .invert (inv_v[i]),
      .q      (out_v[i])
    );
  end

  // default levels pass through when bits clear
  assign AUDIO_FRAME_MARKER    = out_v[O_AFM];
  assign TEN_FIELD_IDENTIFIER  = out_v[O_TFD];
  assign DISPLAY_WINDOW_ENABLE = out_v[O_DEW];
  assign FIELD_DIGITAL         = out_v[O_FDG];
  assign FIELD_SYNC            = out_v[O_FSY];
  assign VBLANK                = out_v[O_VBL];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  // each pin is raw xor invert, one edge late, skipped at reset exit
  AST_AFM_XOR: assert property ((HAS_AUDIO && NRST) |=> AUDIO_FRAME_MARKER ==
      ($past(AUDIO_FRAME_MARKER_RAW) ^ $past(polarity[BIT_AFM])))
    else $error("marker polarity wrong");
  AST_AFM_NONE: assert property (!HAS_AUDIO |=> !AUDIO_FRAME_MARKER)
    else $error("marker pulsed without audio");
  AST_TFD_XOR: assert property (NRST |=> TEN_FIELD_IDENTIFIER ==
      ($past(TEN_FIELD_IDENTIFIER_RAW) ^ $past(polarity[BIT_TENFID])))
    else $error("identifier polarity wrong");
  AST_DEW_XOR: assert property (NRST |=> DISPLAY_WINDOW_ENABLE ==
      ($past(DISPLAY_WINDOW_ENABLE_RAW) ^ $past(polarity[BIT_DEWIN])))
    else $error("display enable polarity wrong");
  AST_FDG_XOR: assert property (NRST |=> FIELD_DIGITAL ==
      ($past(FIELD_DIGITAL_RAW) ^ $past(polarity[BIT_FDIG])))
    else $error("field flag polarity wrong");
  AST_FSY_XOR: assert property (NRST |=> FIELD_SYNC ==
      ($past(FIELD_SYNC_RAW) ^ $past(polarity[BIT_FSYNC])))
    else $error("field sync polarity wrong");
  AST_VBL_XOR: assert property (NRST |=> VBLANK ==
      ($past(VBLANK_RAW) ^ $past(polarity[BIT_VBLANK])))
    else $error("blanking polarity wrong");
  AST_RSV_ZERO: assert property ((polarity & ~POL_WMASK) == 16'h0000)
    else $error("reserved bits stored");
  AST_WR_VBL: assert property ((do_write && PSTRB[0]) |=> ##1
      VBLANK == ($past(VBLANK_RAW) ^ $past(PWDATA[BIT_VBLANK], 2)))
    else $error("written invert not applied");
  AST_PREADY: assert property (setup |=> PREADY ##1 !PREADY)
    else $error("apb answer timing wrong");

  // reset leaves register at default polarity and all pins low
  AST_RST_CLR: assert property (disable iff (1'b0)
      !$past(NRST) |-> (polarity == POL_RESET && out_v == '0))
    else $error("reset did not clear");
  // no-audio variant never stores the marker bit
  AST_AFM_MASK: assert property (!HAS_AUDIO |-> !polarity[BIT_AFM])
    else $error("marker bit stored without audio");
  // error flag only rides with ready
  AST_ERR_RDY: assert property (PSLVERR |-> PREADY)
    else $error("error flag without ready");
  // unmapped setup is answered with the error flag
  AST_ERR_ADDR: assert property ((setup && !mapped) |=> PSLVERR)
    else $error("unmapped address not refused");
  // a refused access leaves the register alone
  AST_ERR_KEEP: assert property ((PSEL && PENABLE && PREADY && !hit_pol)
      |=> polarity == $past(polarity))
    else $error("register changed by foreign access");
  // read data shows the stored word in the access cycle
  AST_RD_DATA: assert property ((setup && !PWRITE && hit_pol)
      |=> PRDATA == {16'h0000, $past(polarity)})
    else $error("read data wrong");
  // read data bus is quiet outside the answer cycle
  AST_RD_IDLE: assert property (!PREADY |-> PRDATA == 32'h00000000)
    else $error("read data outside answer");

  COV_WRITE: cover property (do_write);
  COV_READ: cover property (PSEL && PENABLE && PREADY && !PWRITE && hit_pol);
  COV_INV_DE: cover property (polarity[BIT_DEWIN] && DISPLAY_WINDOW_ENABLE_RAW);
  COV_ERR: cover property (PSLVERR);

endmodule
`default_nettype wire

// ==== verif/timing_sink.sv ====
// display side model: latches the six timing levels
// assumes: levels are synchronous to the same clock
`timescale 1ns/1ps
`default_nettype none
module timing_sink (
  // clock
  input  wire logic       clk,
  // timing levels as received
  input  wire logic [5:0] level,
  output var  logic [5:0] seen
);
  // one register stage, as a receiving flop would
  always_ff @(posedge clk) begin
    seen <= level;
  end
endmodule
`default_nettype wire

// ==== verif/timing_output_polarity_ctl_test.sv ====
// self-checking bench for the polarity block
// assumes: apb answers with one access cycle, outputs one flop late
`timescale 1ns/1ps
`default_nettype none
module timing_output_polarity_ctl_test;
  import tpol_pkg::*;
  // ****************
  // signals
  // ****************
  logic clk_sys, nrst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] prdata_na, rd_na;
  logic pready_na, pslverr_na;
  logic [5:0] outs_na;
  logic [3:0]  pstrb;
  logic pready, pslverr, er;
  logic [5:0] raw, outs, seen;
  int errors, checked;
  int pos[6] = '{BIT_AFM, BIT_TENFID, BIT_DEWIN, BIT_FDIG, BIT_FSYNC,
                 BIT_VBLANK};
  // design and display model
  timing_output_polarity_ctl dut (.CLK_SYS(clk_sys), .NRST(nrst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .AUDIO_FRAME_MARKER_RAW(raw[O_AFM]),
    .TEN_FIELD_IDENTIFIER_RAW(raw[O_TFD]),
    .DISPLAY_WINDOW_ENABLE_RAW(raw[O_DEW]),
    .FIELD_DIGITAL_RAW(raw[O_FDG]), .FIELD_SYNC_RAW(raw[O_FSY]),
    .VBLANK_RAW(raw[O_VBL]), .AUDIO_FRAME_MARKER(outs[O_AFM]),
    .TEN_FIELD_IDENTIFIER(outs[O_TFD]),
    .DISPLAY_WINDOW_ENABLE(outs[O_DEW]), .FIELD_DIGITAL(outs[O_FDG]),
    .FIELD_SYNC(outs[O_FSY]), .VBLANK(outs[O_VBL]));
  // variant without audio clocks on the same bus, reads kept apart
  timing_output_polarity_ctl #(.HAS_AUDIO(1'b0)) dut_na (
    .CLK_SYS(clk_sys), .NRST(nrst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata_na),
    .PREADY(pready_na), .PSLVERR(pslverr_na),
    .AUDIO_FRAME_MARKER_RAW(raw[O_AFM]),
    .TEN_FIELD_IDENTIFIER_RAW(raw[O_TFD]),
    .DISPLAY_WINDOW_ENABLE_RAW(raw[O_DEW]),
    .FIELD_DIGITAL_RAW(raw[O_FDG]), .FIELD_SYNC_RAW(raw[O_FSY]),
    .VBLANK_RAW(raw[O_VBL]), .AUDIO_FRAME_MARKER(outs_na[O_AFM]),
    .TEN_FIELD_IDENTIFIER(outs_na[O_TFD]),
    .DISPLAY_WINDOW_ENABLE(outs_na[O_DEW]),
    .FIELD_DIGITAL(outs_na[O_FDG]),
    .FIELD_SYNC(outs_na[O_FSY]), .VBLANK(outs_na[O_VBL]));
  timing_sink sink (.clk(clk_sys), .level(outs), .seen(seen));
  // 100 mhz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ****************
  // tasks
  // ****************
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h1, 32'h0);
    rd = prdata;
    rd_na = prdata_na;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // register clears on reset
  task automatic test_reset;
    apb(1'b0, POL_REG_ADDR, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h0);
    chk({26'h0, outs}, 32'h0);
  endtask
  // each invert bit alone, raw low then raw high
  task automatic test_bits;
    for (int i = 0; i < 6; i++) begin
      for (int r = 0; r < 2; r++) begin
        raw <= {6{r[0]}};
        apb(1'b1, POL_REG_ADDR, 32'h1 << pos[i]);
        repeat (2) @(posedge clk_sys);
        chk({26'h0, seen}, {26'h0, {6{r[0]}} ^ (6'h1 << i)});
      end
    end
  endtask
  // reserved bits read zero, unmapped address refused
  task automatic test_reserved;
    apb(1'b1, POL_REG_ADDR, 32'hffff_ffff);
    apb(1'b0, POL_REG_ADDR, 32'h0);
    chk(rd, {16'h0, POL_WMASK});
    apb(1'b0, 12'h004, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, POL_REG_ADDR, 32'h0);
    apb(1'b1, 12'h004, 32'hffff_ffff);
    chk({31'h0, er}, 32'h1);
    pstrb <= 4'h2;
    apb(1'b1, POL_REG_ADDR, 32'hffff_ffff);
    pstrb <= 4'hf;
    apb(1'b0, POL_REG_ADDR, 32'h0);
    chk(rd, {16'h0, POL_WMASK & 16'hff00});
    apb(1'b1, POL_REG_ADDR, 32'h0);
  endtask
  // variant without audio ignores the marker bit
  task automatic test_no_audio;
    raw <= 6'h3f;
    apb(1'b1, POL_REG_ADDR, 32'h1 << BIT_AFM);
    apb(1'b0, POL_REG_ADDR, 32'h0);
    chk(rd, 32'h1 << BIT_AFM);
    chk(rd_na, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, outs[O_AFM]}, 32'h0);
    chk({26'h0, outs_na}, 32'h3e);
    raw <= 6'h0;
    apb(1'b1, POL_REG_ADDR, 32'h0);
  endtask
  // reset in mid run clears register and pins
  task automatic test_midreset;
    raw <= 6'h3f;
    apb(1'b1, POL_REG_ADDR, 32'h1 << BIT_DEWIN);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({26'h0, outs}, 32'h0);
    nrst <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, POL_REG_ADDR, 32'h0);
    chk(rd, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({26'h0, outs}, 32'h3f);
    raw <= 6'h0;
  endtask
  // verdict
  task automatic print_verdict;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, raw} = '0;
    pstrb = 4'hf;
    errors = 0;
    checked = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    test_reset();
    test_bits();
    test_reserved();
    test_no_audio();
    test_midreset();
    print_verdict();
  end
  // hang guard
  initial begin
    #50000;
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
